// *** inc/pwmoc_pkg.sv ***
// Constants and types for the PWM output override and trigger block
// Operation
// RULE1 - Swap set: generator high to low pin
// RULE2 - Swap clear: each output on own pin
// RULE3 - Sync set: forced data at period boundary
// RULE4 - Sync clear: forced data next clock
// RULE5 - Software leaves fields alone while running
// RULE6 - Write protect needs unlock before control write
// RULE7 - Local time base compare raises trigger
// RULE8 - Trigger compare 16 bits, RW, reset zero
// RULE9 - Pair mode: complementary, redundant, push-pull
// RULE10 - Low polarity one inverts low pin
// RULE11 - Override drives high bit1, low bit0
// RULE12 - Fault or limit drives data bits
package pwmoc_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam int PWMOC_AW = 4;
   localparam int PWMOC_DW = 16;
   localparam logic [3:0] PWMOC_OFF_CTRL = 4'h0;
   localparam logic [3:0] PWMOC_OFF_TRIG = 4'h1;
   localparam logic [3:0] PWMOC_OFF_UNLOCK = 4'h2;
   localparam logic [3:0] PWMOC_OFF_STATUS = 4'h3;
   localparam logic [15:0] PWMOC_CTRL_RESET = 16'h0000;
   localparam logic [15:0] PWMOC_TRIG_RESET = 16'h0000;
   localparam logic [15:0] PWMOC_UNLOCK_KEY1 = 16'h00aa;
   localparam logic [15:0] PWMOC_UNLOCK_KEY2 = 16'h0055;
   // ****************************************
   // Control field positions
   // ****************************************
   localparam int PWMOC_B_POLH = 13;
   localparam int PWMOC_B_POLL = 12;
   localparam int PWMOC_B_MODE = 10;
   localparam int PWMOC_B_OVRH = 9;
   localparam int PWMOC_B_OVRL = 8;
   localparam int PWMOC_B_FORCED = 6;
   localparam int PWMOC_B_FAULT = 4;
   localparam int PWMOC_B_LIMIT = 2;
   localparam int PWMOC_B_SWAP = 1;
   localparam int PWMOC_B_SYNC = 0;
   localparam logic [15:0] PWMOC_CTRL_MASK = 16'h3fff;
   typedef enum logic [1:0] {
      PWMOC_MODE_COMP = 2'b00,
      PWMOC_MODE_RED = 2'b01,
      PWMOC_MODE_PP = 2'b10,
      PWMOC_MODE_RSV = 2'b11
   } pwmoc_mode_t;
   typedef enum logic [1:0] {
      PWMOC_UL_IDLE = 2'b00,
      PWMOC_UL_KEY1 = 2'b01,
      PWMOC_UL_OPEN = 2'b10
   } pwmoc_ul_t;
endpackage

// *** inc/pwmoc_cfg_if.sv ***
// Configuration carrier between register file and pin stage
`timescale 1ns/1ps
interface pwmoc_cfg_if;
   logic [15:0] ctrl;
   logic [1:0] forced;
   modport src (output ctrl, output forced);
   modport dst (input ctrl, input forced);
endinterface

// *** hdl/pwmoc_pins.sv ***
// Pin stage: mode, override, fault, swap and polarity
`timescale 1ns/1ps
module pwmoc_pins
   import pwmoc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   pwmoc_cfg_if.dst cfg,
   input wire logic gen_high,
   input wire logic gen_low,
   input wire logic fault_active,
   input wire logic limit_active,
   output logic pin_high_d,
   output logic pin_low_d
);
   logic h, l;
   logic [1:0] mode;
   always_comb begin
      mode = cfg.ctrl[PWMOC_B_MODE +: 2];
      // RULE9 pair mode decode
      unique case (mode)
         PWMOC_MODE_RED: begin
            h = gen_high;
            l = gen_high;
         end
         PWMOC_MODE_PP: begin
            h = gen_high;
            l = gen_low;
         end
         PWMOC_MODE_COMP: begin
            h = gen_high;
            l = ~gen_high;
         end
         default: begin
            h = 1'b0;
            l = 1'b0;
         end
      endcase
      // RULE1 RULE2 swap select
      if (cfg.ctrl[PWMOC_B_SWAP]) begin
         {h, l} = {l, h};
      end
      // RULE11 forced pin data
      if (cfg.ctrl[PWMOC_B_OVRH]) begin
         h = cfg.forced[1];
      end
      if (cfg.ctrl[PWMOC_B_OVRL]) begin
         l = cfg.forced[0];
      end
      // RULE12 fault before limit
      if (fault_active) begin
         h = cfg.ctrl[PWMOC_B_FAULT + 1];
         l = cfg.ctrl[PWMOC_B_FAULT];
      end else if (limit_active) begin
         h = cfg.ctrl[PWMOC_B_LIMIT + 1];
         l = cfg.ctrl[PWMOC_B_LIMIT];
      end
      // RULE10 polarity inversion
      pin_high_d = h ^ cfg.ctrl[PWMOC_B_POLH];
      pin_low_d = l ^ cfg.ctrl[PWMOC_B_POLL];
   end
   AST_SWAP_CROSS: assert property (@(posedge clk) disable iff (reset) // RULE1
      mode == PWMOC_MODE_PP && cfg.ctrl[PWMOC_B_SWAP] && !cfg.ctrl[PWMOC_B_OVRH]
      && !fault_active && !limit_active
      |-> pin_high_d == (gen_low ^ cfg.ctrl[PWMOC_B_POLH]))
      else $error("Swap did not route low to high pin");
endmodule

// *** hdl/pwmoc_top.sv ***
// Top: registers, unlock, trigger compare and pin registers
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
module pwmoc_top
   import pwmoc_pkg::*;
#(
   parameter int DW = PWMOC_DW
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [PWMOC_AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DW-1:0] rdata,
   input wire logic write_protect_config,
   input wire logic module_run_enable,
   input wire logic period_boundary,
   input wire logic [DW-1:0] time_base_count,
   input wire logic gen_high,
   input wire logic gen_low,
   input wire logic fault_active,
   input wire logic limit_active,
   output logic high_side_pin,
   output logic low_side_pin,
   output logic adc_trigger
);
   // ****************************************
   // Register state
   // ****************************************
   logic [15:0] ctrl_q, ctrl_d;
   logic [DW-1:0] trig_q, trig_d;
   logic [1:0] forced_q, forced_d;
   logic [DW-1:0] rdata_q, rdata_d;
   logic rejected_q, rejected_d;
   pwmoc_ul_t ul_q, ul_d;
   logic hp_q, hp_d, lp_q, lp_d, trg_q, trg_d;
   logic ctrl_wr;
   pwmoc_cfg_if cfg ();
   assign cfg.ctrl = ctrl_q;
   assign cfg.forced = forced_q;

   always_comb begin
      ctrl_d = ctrl_q;
      trig_d = trig_q;
      ul_d = ul_q;
      rejected_d = rejected_q;
      rdata_d = '0;
      ctrl_wr = wr && addr == PWMOC_OFF_CTRL;
      // Two-word key opens one control write
      if (wr && addr == PWMOC_OFF_UNLOCK) begin
         ul_d = (wdata == PWMOC_UNLOCK_KEY1) ? PWMOC_UL_KEY1 :
            (ul_q == PWMOC_UL_KEY1 && wdata == PWMOC_UNLOCK_KEY2) ? PWMOC_UL_OPEN : PWMOC_UL_IDLE;
      end else if (wr) begin
         ul_d = PWMOC_UL_IDLE;
      end
      // Clear first so a refused write below wins
      if (rd && addr == PWMOC_OFF_STATUS) begin
         rejected_d = 1'b0;
      end
      // RULE6 locked write refused
      if (ctrl_wr) begin
         if (!write_protect_config || ul_q == PWMOC_UL_OPEN) begin
            ctrl_d = wdata[15:0] & PWMOC_CTRL_MASK;
         end else begin
            rejected_d = 1'b1;
         end
      end
      // RULE8 trigger compare storage
      if (wr && addr == PWMOC_OFF_TRIG) begin
         trig_d = wdata;
      end
      if (rd) begin
         unique case (addr)
            PWMOC_OFF_CTRL: rdata_d = DW'(ctrl_q);
            PWMOC_OFF_TRIG: rdata_d = trig_q;
            PWMOC_OFF_STATUS: rdata_d = DW'({rejected_q, ul_q == PWMOC_UL_OPEN, lp_q, hp_q});
            default: rdata_d = '0;
         endcase
      end
   end

   // ****************************************
   // Forced data timing
   // ****************************************
   always_comb begin
      forced_d = forced_q;
      // RULE3 RULE4 sync select
      if (!ctrl_q[PWMOC_B_SYNC] || period_boundary) begin
         forced_d = ctrl_q[PWMOC_B_FORCED +: 2];
      end
   end

   logic ph, pl;
   pwmoc_pins u_pins (
      .clk(clk),
      .reset(reset),
      .cfg(cfg),
      .gen_high(gen_high),
      .gen_low(gen_low),
      .fault_active(fault_active),
      .limit_active(limit_active),
      .pin_high_d(ph),
      .pin_low_d(pl)
   );

   always_comb begin
      hp_d = ph;
      lp_d = pl;
      // RULE7 compare raises trigger
      trg_d = (time_base_count == trig_q);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_q <= PWMOC_CTRL_RESET;
         trig_q <= PWMOC_TRIG_RESET;
         forced_q <= '0;
         rdata_q <= '0;
         rejected_q <= 1'b0;
         ul_q <= PWMOC_UL_IDLE;
         hp_q <= 1'b0;
         lp_q <= 1'b0;
         trg_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         trig_q <= trig_d;
         forced_q <= forced_d;
         rdata_q <= rdata_d;
         rejected_q <= rejected_d;
         ul_q <= ul_d;
         hp_q <= hp_d;
         lp_q <= lp_d;
         trg_q <= trg_d;
      end
   end
   assign rdata = rdata_q;
   assign high_side_pin = hp_q;
   assign low_side_pin = lp_q;
   assign adc_trigger = trg_q;

   // ****************************************
   // Checks
   // ****************************************
   AST_LOCKED_WRITE: assert property (@(posedge clk) disable iff (reset) // RULE6
      ctrl_wr && write_protect_config && ul_q != PWMOC_UL_OPEN |=> $stable(ctrl_q))
      else $error("Locked control write took effect");
   AST_UNLOCKED_WRITE: assert property (@(posedge clk) disable iff (reset) // RULE6
      ctrl_wr && !write_protect_config |=> ctrl_q == ($past(wdata[15:0]) & PWMOC_CTRL_MASK))
      else $error("Open control write lost");
   AST_TRIG_WRITE: assert property (@(posedge clk) disable iff (reset) // RULE8
      wr && addr == PWMOC_OFF_TRIG |=> trig_q == $past(wdata))
      else $error("Trigger compare not stored");
   AST_TRIG_FIRE: assert property (@(posedge clk) disable iff (reset) // RULE7
      time_base_count == trig_q && !(wr && addr == PWMOC_OFF_TRIG) |=> adc_trigger)
      else $error("Trigger missed at compare");
   AST_SYNC_HOLD: assert property (@(posedge clk) disable iff (reset) // RULE3
      ctrl_q[PWMOC_B_SYNC] && !period_boundary |=> $stable(forced_q))
      else $error("Forced data moved between boundaries");
   AST_ASYNC_APPLY: assert property (@(posedge clk) disable iff (reset) // RULE4
      !ctrl_q[PWMOC_B_SYNC] |=> forced_q == $past(ctrl_q[PWMOC_B_FORCED +: 2]))
      else $error("Forced data late without sync");
   AST_OVR_HIGH: assert property (@(posedge clk) disable iff (reset) // RULE11
      ctrl_q[PWMOC_B_OVRH] && !fault_active && !limit_active
      |=> high_side_pin == ($past(forced_q[1]) ^ $past(ctrl_q[PWMOC_B_POLH])))
      else $error("High pin ignores forced data");
   AST_FAULT_LOW: assert property (@(posedge clk) disable iff (reset) // RULE12
      fault_active |=> low_side_pin == ($past(ctrl_q[PWMOC_B_FAULT]) ^ $past(ctrl_q[PWMOC_B_POLL])))
      else $error("Low pin ignores fault data");
   AST_PP_SWAP: assert property (@(posedge clk) disable iff (reset) // RULE1
      ctrl_q[PWMOC_B_MODE +: 2] == PWMOC_MODE_PP && ctrl_q[PWMOC_B_SWAP] && ctrl_q[PWMOC_B_POLL +: 4] == 4'h0
      && !ctrl_q[PWMOC_B_OVRL] && !fault_active && !limit_active
      |=> low_side_pin == $past(gen_high))
      else $error("Swap did not route high to low pin");
   // ****************************************
   // Pin and register checks
   // ****************************************
   AST_PP_STRAIGHT: assert property (@(posedge clk) disable iff (reset) // RULE2
      ctrl_q[PWMOC_B_MODE +: 2] == PWMOC_MODE_PP && !ctrl_q[PWMOC_B_SWAP] && ctrl_q[PWMOC_B_POLL +: 4] == 4'h0
      && !ctrl_q[PWMOC_B_OVRH] && !ctrl_q[PWMOC_B_OVRL] && !fault_active && !limit_active
      |=> high_side_pin == $past(gen_high) && low_side_pin == $past(gen_low))
      else $error("Unswapped pins not on own outputs");
   AST_RED_PAIR: assert property (@(posedge clk) disable iff (reset) // RULE9
      ctrl_q[PWMOC_B_MODE +: 2] == PWMOC_MODE_RED && ctrl_q[PWMOC_B_POLL +: 2] == 2'h0
      && !ctrl_q[PWMOC_B_OVRH] && !ctrl_q[PWMOC_B_OVRL] && !fault_active && !limit_active
      |=> high_side_pin == low_side_pin)
      else $error("Redundant pins differ");
   AST_COMP_PAIR: assert property (@(posedge clk) disable iff (reset) // RULE9
      ctrl_q[PWMOC_B_MODE +: 2] == PWMOC_MODE_COMP && ctrl_q[PWMOC_B_POLL +: 2] == 2'h0
      && !ctrl_q[PWMOC_B_OVRH] && !ctrl_q[PWMOC_B_OVRL] && !fault_active && !limit_active
      |=> high_side_pin != low_side_pin)
      else $error("Complementary pins equal");
   AST_RSV_IDLE: assert property (@(posedge clk) disable iff (reset) // RULE9
      ctrl_q[PWMOC_B_MODE +: 2] == PWMOC_MODE_RSV && !ctrl_q[PWMOC_B_OVRH] && !ctrl_q[PWMOC_B_OVRL]
      && !fault_active && !limit_active
      |=> high_side_pin == $past(ctrl_q[PWMOC_B_POLH]) && low_side_pin == $past(ctrl_q[PWMOC_B_POLL]))
      else $error("Reserved mode did not idle pins");
   AST_OVR_LOW: assert property (@(posedge clk) disable iff (reset) // RULE11
      ctrl_q[PWMOC_B_OVRL] && !fault_active && !limit_active
      |=> low_side_pin == ($past(forced_q[0]) ^ $past(ctrl_q[PWMOC_B_POLL])))
      else $error("Low pin ignores forced data");
   AST_FAULT_HIGH: assert property (@(posedge clk) disable iff (reset) // RULE12
      fault_active |=> high_side_pin == ($past(ctrl_q[PWMOC_B_FAULT + 1]) ^ $past(ctrl_q[PWMOC_B_POLH])))
      else $error("High pin ignores fault data");
   AST_LIMIT_PAIR: assert property (@(posedge clk) disable iff (reset) // RULE12
      limit_active && !fault_active
      |=> high_side_pin == ($past(ctrl_q[PWMOC_B_LIMIT + 1]) ^ $past(ctrl_q[PWMOC_B_POLH]))
      && low_side_pin == ($past(ctrl_q[PWMOC_B_LIMIT]) ^ $past(ctrl_q[PWMOC_B_POLL])))
      else $error("Pins ignore limit data");
   AST_TRIG_QUIET: assert property (@(posedge clk) disable iff (reset) // RULE7
      time_base_count != trig_q |=> !adc_trigger)
      else $error("Trigger raised off compare");
   AST_TRIG_READ: assert property (@(posedge clk) disable iff (reset) // RULE8
      rd && addr == PWMOC_OFF_TRIG |=> rdata == $past(trig_q))
      else $error("Trigger compare read wrong");
   AST_REJECT_SET: assert property (@(posedge clk) disable iff (reset) // RULE6
      ctrl_wr && write_protect_config && ul_q != PWMOC_UL_OPEN |=> rejected_q)
      else $error("Refused write not flagged");
   AST_STATUS_CLEAR: assert property (@(posedge clk) disable iff (reset) // RULE6
      rd && addr == PWMOC_OFF_STATUS && !ctrl_wr |=> !rejected_q)
      else $error("Status read left reject flag");
   AST_OPEN_WRITE: assert property (@(posedge clk) disable iff (reset) // RULE6
      ctrl_wr && ul_q == PWMOC_UL_OPEN |=> ctrl_q == ($past(wdata[15:0]) & PWMOC_CTRL_MASK))
      else $error("Unlocked control write lost");
   AST_UNLOCK_ONCE: assert property (@(posedge clk) disable iff (reset) // RULE6
      ul_q == PWMOC_UL_OPEN && wr |=> ul_q != PWMOC_UL_OPEN)
      else $error("Unlock outlived one write");
endmodule

// *** verification/pwmoc_stage_model.sv ***
// Time base and generator model at the far side of the block
`timescale 1ns/1ps
module pwmoc_stage_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic hold,
   input wire logic adc_trigger,
   output logic [15:0] time_base_count,
   output logic period_boundary,
   output logic gen_high,
   output logic gen_low,
   output int trig_seen
);
   logic [15:0] cnt_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_q <= 16'h0000;
         trig_seen <= 0;
      end else begin
         if (!hold) begin
            cnt_q <= (cnt_q == 16'h000f) ? 16'h0000 : cnt_q + 16'h0001;
         end
         if (adc_trigger) begin
            trig_seen <= trig_seen + 1;
         end
      end
   end
   assign time_base_count = cnt_q;
   // Frozen time base gives no boundary
   assign period_boundary = !hold && (cnt_q == 16'h000f);
   assign gen_high = ~cnt_q[3];
   assign gen_low = cnt_q[2];
endmodule

// *** verification/pwmoc_top_tb.sv ***
// Self-checking bench for the PWM output override and trigger block
`timescale 1ns/1ps
module pwmoc_top_tb;
   import pwmoc_pkg::*;
   logic clk, reset, wr, rd, wp, run, hold, fault, limit, ph, pl, trig, pb, gh, gl;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, tbc, got;
   int fail_count, num_checks, seen, s0;
   logic [15:0] cv [11] = '{16'h0000, 16'h0400, 16'h0c00, 16'h0002, 16'h1000, 16'h1400, 16'h0340, 16'h0b40,
      16'h0800, 16'h0802, 16'h2800};
   logic [1:0] ev [11] = '{2'b10, 2'b11, 2'b00, 2'b01, 2'b11, 2'b10, 2'b01, 2'b01, 2'b10, 2'b01, 2'b00};
   pwmoc_stage_model u_model (.clk(clk), .reset(reset), .hold(hold), .adc_trigger(trig),
      .time_base_count(tbc), .period_boundary(pb), .gen_high(gh), .gen_low(gl), .trig_seen(seen));
   pwmoc_top u_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .write_protect_config(wp), .module_run_enable(run), .period_boundary(pb),
      .time_base_count(tbc), .gen_high(gh), .gen_low(gl), .fault_active(fault),
      .limit_active(limit), .high_side_pin(ph), .low_side_pin(pl), .adc_trigger(trig));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic end_of_test;
      if (fail_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [15:0] e, input string n);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(n, e, rdata);
   endtask
   task automatic pins(input logic [1:0] e);
      repeat (3) @(posedge clk);
      #1;
      chk("pins", {14'h0000, e}, {14'h0000, ph, pl});
   endtask
   // Bounded wait for a time base value
   task automatic wait_cnt(input logic [15:0] c);
      for (int i = 0; i <= 40; i++) begin
         @(posedge clk);
         #1;
         if (tbc === c) begin
            return;
         end
      end
      fail_count++;
      end_of_test();
   endtask
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      {reset, wr, rd, wp, run, hold, fault, limit} = 8'h80;
      addr = 4'h0;
      wdata = 16'h0000;
      // Fields only change with the module stopped
      run = 1'b0;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      rd_reg(PWMOC_OFF_CTRL, PWMOC_CTRL_RESET, "ctrl reset");
      rd_reg(PWMOC_OFF_TRIG, 16'h0000, "trig reset");
      rd_reg(4'h9, 16'h0000, "unmapped");
      wr_reg(PWMOC_OFF_TRIG, 16'hffff);
      rd_reg(PWMOC_OFF_TRIG, 16'hffff, "trig rw");
      wp <= 1'b1;
      // Fault with zero data pins both status pin bits low
      fault <= 1'b1;
      wr_reg(PWMOC_OFF_CTRL, 16'h0002);
      rd_reg(PWMOC_OFF_CTRL, 16'h0000, "locked ctrl");
      rd_reg(PWMOC_OFF_STATUS, 16'h0008, "status");
      wr_reg(PWMOC_OFF_UNLOCK, PWMOC_UNLOCK_KEY1);
      wr_reg(PWMOC_OFF_UNLOCK, PWMOC_UNLOCK_KEY2);
      rd_reg(PWMOC_OFF_STATUS, 16'h0004, "status open");
      wr_reg(PWMOC_OFF_CTRL, 16'h0400);
      wr_reg(PWMOC_OFF_CTRL, 16'h0000);
      rd_reg(PWMOC_OFF_CTRL, 16'h0400, "unlocked ctrl");
      rd_reg(PWMOC_OFF_STATUS, 16'h0008, "status closed");
      wp <= 1'b0;
      fault <= 1'b0;
      // Count 3 freezes generator high at 1 and low at 0
      wait_cnt(16'h0003);
      hold <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         wr_reg(PWMOC_OFF_CTRL, cv[i]);
         pins(ev[i]);
      end
      wr_reg(PWMOC_OFF_CTRL, 16'h0018);
      fault <= 1'b1;
      pins(2'b01);
      limit <= 1'b1;
      pins(2'b01);
      fault <= 1'b0;
      pins(2'b10);
      limit <= 1'b0;
      wr_reg(PWMOC_OFF_CTRL, 16'h0300);
      wr_reg(PWMOC_OFF_CTRL, 16'h03c1);
      pins(2'b00);
      hold <= 1'b0;
      wait_cnt(16'h0000);
      pins(2'b11);
      wr_reg(PWMOC_OFF_TRIG, 16'h0005);
      s0 = seen;
      repeat (64) @(posedge clk);
      #1;
      chk("triggers", 16'h0004, 16'(seen - s0));
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rd_reg(PWMOC_OFF_TRIG, 16'h0000, "trig after reset");
      end_of_test();
   end
endmodule
